//--- common/pls_regs.svh
// Register map, field positions, reset values and timing figures of the panel power sequencer
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PLS_ADDR_W          4
`define PLS_ADDR_CTRL       4'h0
`define PLS_ADDR_STATUS     4'h4
`define PLS_ADDR_HTOTAL     4'h8
`define PLS_ADDR_VTOTAL     4'hC

// ****************************************
// Field positions
// ****************************************
`define PLS_CTRL_PWR        0
`define PLS_CTRL_M48        1
`define PLS_STAT_ST_LSB     0
`define PLS_STAT_ST_MSB     3
`define PLS_STAT_HPD        4
`define PLS_STAT_ERR_HPD    8
`define PLS_STAT_ERR_TIM    9

// ****************************************
// Frame geometry
// ****************************************
`define PLS_HTOT_W          12
`define PLS_VTOT_W          11
`define PLS_HTOT_MIN        12'h8B6
`define PLS_HTOT_MAX        12'h8DE
`define PLS_HTOT_RST        12'h8CA
`define PLS_HACT            12'h780
`define PLS_VTOT_MIN        11'h468
`define PLS_VTOT_MAX        11'h470
`define PLS_VTOT_RST        11'h46C
`define PLS_VACT            11'h438

// ****************************************
// Times in ms, clock in kHz
// ****************************************
`define PLS_CLK_KHZ         32'h000186A0
`define PLS_HPD_MS          32'h000000C8
`define PLS_T8_MS           32'h00000050
`define PLS_BLL_MS          32'h00000032
`define PLS_TC_MS           32'h00000001
`define PLS_TD_MS           32'h00000001
`define PLS_T12_MS          32'h000001F4
`define PLS_TMR_W           26

`endif

//--- common/pls_pkg.sv
// Types shared by the panel power sequencer
`include "pls_regs.svh"

package pls_pkg;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        PLS_OFF      = 4'b0000,
        PLS_RAIL_UP  = 4'b0001,
        PLS_CAPS     = 4'b0010,
        PLS_TRAIN    = 4'b0011,
        PLS_IDLE     = 4'b0100,
        PLS_VID_WAIT = 4'b0101,
        PLS_LED_UP   = 4'b0110,
        PLS_BL_ON    = 4'b0111,
        PLS_RUN      = 4'b1000,
        PLS_BL_DOWN  = 4'b1001,
        PLS_LED_DOWN = 4'b1010,
        PLS_VID_HOLD = 4'b1011,
        PLS_VID_END  = 4'b1100,
        PLS_REST     = 4'b1101
    } pls_state_type;

    // ****************************************
    // Whole state of the sequencer
    // ****************************************
    typedef struct packed {
        pls_state_type           st;
        logic                    pwr_req;
        logic                    mode48;
        logic [`PLS_HTOT_W-1:0]  htot;
        logic [`PLS_VTOT_W-1:0]  vtot;
        logic                    err_hpd;
        logic                    err_tim;
        logic                    rail;
        logic                    led;
        logic                    dim;
        logic                    bl;
        logic                    train;
        logic                    idle;
        logic                    video;
        logic                    novideo;
        logic [31:0]             rdata;
    } pls_seq_type;

    typedef struct packed {
        logic [`PLS_TMR_W-1:0]   cnt;
    } pls_tmr_type;

endpackage

//--- design/pls_timer.sv
// One-shot down counter used for every sequencing delay
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_timer
    import pls_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Control
    input  wire logic                  load,
    input  wire logic [`PLS_TMR_W-1:0] value,
    // Status
    output logic                       expired
);

    pls_tmr_type s_r;
    pls_tmr_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.cnt = value;
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = (s_r.cnt == '0);

endmodule // pls_timer

//--- design/pls_host_seq.sv
// Source-side power and backlight sequencer for an embedded display panel
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_host_seq
    import pls_pkg::*;
#(
    parameter int unsigned HPD_WAIT_CYC  = `PLS_HPD_MS * `PLS_CLK_KHZ,
    parameter int unsigned VID_SETTLE_CYC = `PLS_T8_MS * `PLS_CLK_KHZ,
    parameter int unsigned BL_LEAD_CYC   = `PLS_BLL_MS * `PLS_CLK_KHZ,
    parameter int unsigned LED_UP_CYC    = `PLS_TC_MS  * `PLS_CLK_KHZ,
    parameter int unsigned LED_DOWN_CYC  = `PLS_TD_MS  * `PLS_CLK_KHZ,
    parameter int unsigned REST_CYC      = `PLS_T12_MS * `PLS_CLK_KHZ
)(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Software register port
    input  wire logic [`PLS_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    // Panel and link status
    input  wire logic                   hotplug,
    input  wire logic                   caps_done,
    input  wire logic                   train_done,
    input  wire logic                   train_fail,
    input  wire logic                   frame_aligned,
    // Panel supplies and backlight
    output logic                        panel_supply_rail,
    output logic                        led_supply,
    output logic                        dimming_en,
    output logic                        backlight_en,
    // Link and video engine control
    output logic                        train_req,
    output logic                        idle_pattern,
    output logic                        video_valid,
    output logic                        novideo_flag,
    output logic                        pixel_clock_48,
    output logic [`PLS_HTOT_W-1:0]      line_total_clocks,
    output logic [`PLS_VTOT_W-1:0]      frame_total_lines
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic totals_ok(input logic [`PLS_HTOT_W-1:0] h,
                                       input logic [`PLS_VTOT_W-1:0] v);
        totals_ok = (h >= `PLS_HTOT_MIN) && (h <= `PLS_HTOT_MAX) &&
                    (v >= `PLS_VTOT_MIN) && (v <= `PLS_VTOT_MAX);
    endfunction

    function automatic logic [`PLS_TMR_W-1:0] cyc(input int unsigned n);
        cyc = n[`PLS_TMR_W-1:0];
    endfunction

    pls_seq_type s_r;
    pls_seq_type s_nxt;

    logic                  tmr_load;
    logic [`PLS_TMR_W-1:0] tmr_val;
    logic                  tmr_exp;

    pls_timer u_timer (
        .clk     (clk),
        .rst     (rst),
        .load    (tmr_load),
        .value   (tmr_val),
        .expired (tmr_exp)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic clr_hpd;
        logic clr_tim;
        logic set_hpd;
        logic set_tim;
        logic shutdown;
        clr_hpd  = 1'b0;
        clr_tim  = 1'b0;
        set_hpd  = 1'b0;
        set_tim  = 1'b0;
        shutdown = 1'b0;
        s_nxt    = s_r;
        tmr_load = 1'b0;
        tmr_val  = '0;

        // Register writes; geometry only changes while the panel is dark
        if (reg_wr) begin
            case (reg_addr)
                `PLS_ADDR_CTRL: begin
                    s_nxt.pwr_req = reg_wdata[`PLS_CTRL_PWR];
                    if (s_r.st == PLS_OFF) begin
                        s_nxt.mode48 = reg_wdata[`PLS_CTRL_M48];
                    end
                end
                `PLS_ADDR_STATUS: begin
                    clr_hpd = reg_wdata[`PLS_STAT_ERR_HPD];
                    clr_tim = reg_wdata[`PLS_STAT_ERR_TIM];
                end
                `PLS_ADDR_HTOTAL: begin
                    if (s_r.st == PLS_OFF) begin
                        s_nxt.htot = reg_wdata[`PLS_HTOT_W-1:0];
                    end
                end
                `PLS_ADDR_VTOTAL: begin
                    if (s_r.st == PLS_OFF) begin
                        s_nxt.vtot = reg_wdata[`PLS_VTOT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sequencer
        case (s_r.st)
            PLS_OFF: begin
                if (s_r.pwr_req) begin
                    if (totals_ok(s_r.htot, s_r.vtot)) begin
                        s_nxt.rail = 1'b1;
                        s_nxt.st   = PLS_RAIL_UP;
                        tmr_load   = 1'b1;
                        tmr_val    = cyc(HPD_WAIT_CYC);
                    end else begin
                        set_tim = 1'b1;
                        s_nxt.pwr_req = 1'b0;
                    end
                end
            end
            PLS_RAIL_UP: begin
                if (!s_r.pwr_req) begin
                    shutdown = 1'b1;
                end else if (hotplug) begin
                    s_nxt.st = PLS_CAPS;
                end else if (tmr_exp) begin
                    set_hpd  = 1'b1;
                    shutdown = 1'b1;
                end
            end
            PLS_CAPS: begin
                // Capability reads may take as long as the AUX side needs
                if (!s_r.pwr_req) begin
                    shutdown = 1'b1;
                end else if (caps_done) begin
                    s_nxt.train = 1'b1;
                    s_nxt.st    = PLS_TRAIN;
                end
            end
            PLS_TRAIN: begin
                if (!s_r.pwr_req) begin
                    shutdown = 1'b1;
                end else if (train_done) begin
                    s_nxt.train = 1'b0;
                    s_nxt.idle  = 1'b1;
                    s_nxt.st    = PLS_IDLE;
                end else if (train_fail) begin
                    s_nxt.st = PLS_CAPS;
                    s_nxt.train = 1'b0;
                end
            end
            PLS_IDLE: begin
                // Idle pattern held until frames are aligned
                if (!s_r.pwr_req) begin
                    shutdown = 1'b1;
                end else if (frame_aligned) begin
                    s_nxt.idle    = 1'b0;
                    s_nxt.video   = 1'b1;
                    s_nxt.novideo = 1'b0;
                    s_nxt.st      = PLS_VID_WAIT;
                    tmr_load      = 1'b1;
                    tmr_val       = cyc(VID_SETTLE_CYC);
                end
            end
            PLS_VID_WAIT: begin
                if (!s_r.pwr_req) begin
                    s_nxt.st = PLS_VID_END;
                end else if (tmr_exp) begin
                    s_nxt.led = 1'b1;
                    s_nxt.st  = PLS_LED_UP;
                    tmr_load  = 1'b1;
                    tmr_val   = cyc(LED_UP_CYC);
                end
            end
            PLS_LED_UP: begin
                if (!s_r.pwr_req) begin
                    s_nxt.led = 1'b0;
                    s_nxt.st  = PLS_VID_END;
                end else if (tmr_exp) begin
                    s_nxt.dim = 1'b1;
                    s_nxt.st  = PLS_BL_ON;
                end
            end
            PLS_BL_ON: begin
                s_nxt.bl = 1'b1;
                s_nxt.st = PLS_RUN;
            end
            PLS_RUN: begin
                if (!s_r.pwr_req) begin
                    s_nxt.bl = 1'b0;
                    s_nxt.st = PLS_BL_DOWN;
                end
            end
            PLS_BL_DOWN: begin
                s_nxt.dim = 1'b0;
                s_nxt.st  = PLS_LED_DOWN;
                tmr_load  = 1'b1;
                tmr_val   = cyc(LED_DOWN_CYC);
            end
            PLS_LED_DOWN: begin
                if (tmr_exp) begin
                    s_nxt.led = 1'b0;
                    s_nxt.st  = PLS_VID_HOLD;
                    tmr_load  = 1'b1;
                    tmr_val   = cyc(BL_LEAD_CYC);
                end
            end
            PLS_VID_HOLD: begin
                // Video held until the backlight has been dark for more than the lead time
                if (tmr_exp) begin
                    s_nxt.st = PLS_VID_END;
                end
            end
            PLS_VID_END: begin
                s_nxt.video   = 1'b0;
                s_nxt.novideo = 1'b1;
                shutdown      = 1'b1;
            end
            PLS_REST: begin
                // Enforces the off time before the rail may rise again
                if (tmr_exp) begin
                    s_nxt.st = PLS_OFF;
                end
            end
            default: begin
                shutdown = 1'b1;
            end
        endcase

        // Rail drops as video ends, well inside the limit
        if (shutdown) begin
            s_nxt.rail  = 1'b0;
            s_nxt.train = 1'b0;
            s_nxt.idle  = 1'b0;
            s_nxt.video = 1'b0;
            s_nxt.led   = 1'b0;
            s_nxt.dim   = 1'b0;
            s_nxt.bl    = 1'b0;
            s_nxt.st    = PLS_REST;
            tmr_load    = 1'b1;
            tmr_val     = cyc(REST_CYC);
        end

        // Sticky errors: a new event beats a clear in the same cycle
        s_nxt.err_hpd = set_hpd | (s_r.err_hpd & ~clr_hpd);
        s_nxt.err_tim = set_tim | (s_r.err_tim & ~clr_tim);

        // Read data valid only in the cycle after the strobe
        s_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `PLS_ADDR_CTRL: begin
                    s_nxt.rdata[`PLS_CTRL_PWR] = s_r.pwr_req;
                    s_nxt.rdata[`PLS_CTRL_M48] = s_r.mode48;
                end
                `PLS_ADDR_STATUS: begin
                    s_nxt.rdata[`PLS_STAT_ST_MSB:`PLS_STAT_ST_LSB] = s_r.st;
                    s_nxt.rdata[`PLS_STAT_HPD]     = hotplug;
                    s_nxt.rdata[`PLS_STAT_ERR_HPD] = s_r.err_hpd;
                    s_nxt.rdata[`PLS_STAT_ERR_TIM] = s_r.err_tim;
                end
                `PLS_ADDR_HTOTAL: begin
                    s_nxt.rdata[`PLS_HTOT_W-1:0] = s_r.htot;
                end
                `PLS_ADDR_VTOTAL: begin
                    s_nxt.rdata[`PLS_VTOT_W-1:0] = s_r.vtot;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.st      <= PLS_OFF;
            s_r.htot    <= `PLS_HTOT_RST;
            s_r.vtot    <= `PLS_VTOT_RST;
            s_r.novideo <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata         = s_r.rdata;
    assign panel_supply_rail = s_r.rail;
    assign led_supply        = s_r.led;
    assign dimming_en        = s_r.dim;
    assign backlight_en      = s_r.bl;
    assign train_req         = s_r.train;
    assign idle_pattern      = s_r.idle;
    assign video_valid       = s_r.video;
    assign novideo_flag      = s_r.novideo;
    assign pixel_clock_48    = s_r.mode48;
    assign line_total_clocks = s_r.htot;
    assign frame_total_lines = s_r.vtot;

endmodule // pls_host_seq

//--- dv/pls_host_seq_assertions.sv
// Port checker of the panel power sequencer
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_host_seq_chk
    import pls_pkg::*;
#(
    parameter int unsigned VID_SETTLE_CYC = 8,
    parameter int unsigned BL_LEAD_CYC    = 5,
    parameter int unsigned LED_UP_CYC     = 3,
    parameter int unsigned LED_DOWN_CYC   = 3,
    parameter int unsigned REST_CYC       = 10
)(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Supplies and backlight
    input  wire logic                   panel_supply_rail,
    input  wire logic                   led_supply,
    input  wire logic                   dimming_en,
    input  wire logic                   backlight_en,
    // Link and video
    input  wire logic                   train_req,
    input  wire logic                   idle_pattern,
    input  wire logic                   video_valid,
    input  wire logic                   novideo_flag,
    input  wire logic                   pixel_clock_48,
    input  wire logic [`PLS_HTOT_W-1:0] line_total_clocks,
    input  wire logic [`PLS_VTOT_W-1:0] frame_total_lines
);
    // ****************
    // Run-length counters
    // ****************
    // Run lengths turn each spacing rule into one compare
    logic [31:0] vid_cnt_r, led_cnt_r, dim_off_r, bl_off_r, rail_off_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            vid_cnt_r  <= 32'h0;
            led_cnt_r  <= 32'h0;
            dim_off_r  <= 32'h0;
            bl_off_r   <= 32'h0;
            rail_off_r <= 32'(REST_CYC);
        end else begin
            vid_cnt_r  <= video_valid ? vid_cnt_r + 32'h1 : 32'h0;
            led_cnt_r  <= led_supply ? led_cnt_r + 32'h1 : 32'h0;
            dim_off_r  <= dimming_en ? 32'h0 : dim_off_r + 32'h1;
            bl_off_r   <= backlight_en ? 32'h0 : bl_off_r + 32'h1;
            rail_off_r <= panel_supply_rail ? 32'h0 : rail_off_r + 32'h1;
        end
    end

    // ****************
    // Assertions
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    bl_after_dim_a: assert property (backlight_en |-> dimming_en)
        else $error("backlight enable without dimming");
    dim_after_led_a: assert property (dimming_en |-> led_supply)
        else $error("dimming without led supply");
    dim_delay_a: assert property ($rose(dimming_en) |-> led_cnt_r >= LED_UP_CYC)
        else $error("dimming too soon after led supply");
    led_off_delay_a: assert property ($fell(led_supply) |-> dim_off_r >= LED_DOWN_CYC)
        else $error("led supply dropped too soon after dimming");
    led_settle_a: assert property ($rose(led_supply) |-> video_valid && vid_cnt_r >= VID_SETTLE_CYC)
        else $error("led supply before video settled");
    bl_lead_a: assert property ($fell(video_valid) |-> bl_off_r >= BL_LEAD_CYC)
        else $error("video ended too soon after backlight off");
    flag_inverse_a: assert property (novideo_flag != video_valid)
        else $error("no-video flag disagrees with video");
    rail_drop_a: assert property ($fell(video_valid) |=> !panel_supply_rail)
        else $error("rail not removed after video end");
    idle_first_a: assert property ($rose(video_valid) |-> $past(idle_pattern) && !train_req)
        else $error("video started without idle pattern");
    totals_ok_a: assert property (video_valid |-> line_total_clocks inside {[`PLS_HTOT_MIN:`PLS_HTOT_MAX]}
        && frame_total_lines inside {[`PLS_VTOT_MIN:`PLS_VTOT_MAX]}) else $error("video with bad totals");
    mode_hold_a: assert property (video_valid && $past(video_valid) |-> $stable(pixel_clock_48))
        else $error("pixel clock mode changed during video");
    rail_rest_a: assert property ($rose(panel_supply_rail) |-> rail_off_r >= REST_CYC)
        else $error("rail raised before off time");

    run_c: cover property ($rose(backlight_en));
    off_c: cover property ($fell(video_valid));
    m48_c: cover property (video_valid && pixel_clock_48);
endmodule // pls_host_seq_chk

bind pls_host_seq pls_host_seq_chk #(
    .VID_SETTLE_CYC(VID_SETTLE_CYC), .BL_LEAD_CYC(BL_LEAD_CYC), .LED_UP_CYC(LED_UP_CYC),
    .LED_DOWN_CYC(LED_DOWN_CYC), .REST_CYC(REST_CYC)
) u_chk (.clk(clk), .rst(rst), .panel_supply_rail(panel_supply_rail), .led_supply(led_supply),
    .dimming_en(dimming_en), .backlight_en(backlight_en), .train_req(train_req), .idle_pattern(idle_pattern),
    .video_valid(video_valid), .novideo_flag(novideo_flag), .pixel_clock_48(pixel_clock_48),
    .line_total_clocks(line_total_clocks), .frame_total_lines(frame_total_lines));

//--- dv/pls_panel_model.sv
// Behavioural panel sink facing the sequencer
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_panel_model #(
    parameter int unsigned HPD_DLY = 4
)(
    // Clock, reset and test control
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   hpd_block,
    // From the source
    input  wire logic                   panel_supply_rail,
    input  wire logic                   train_req,
    input  wire logic                   idle_pattern,
    input  wire logic                   video_valid,
    input  wire logic                   novideo_flag,
    input  wire logic [`PLS_HTOT_W-1:0] line_total_clocks,
    input  wire logic [`PLS_VTOT_W-1:0] frame_total_lines,
    // To the source
    output logic                        hotplug,
    output logic                        caps_done,
    output logic                        train_done,
    output logic                        train_fail,
    output logic                        frame_aligned,
    // Sink state seen by the bench
    output logic                        sink_status,
    output logic                        black_video
);
    logic [7:0] up_cnt_r;
    logic       timing_ok, tried_r;
    assign timing_ok = line_total_clocks inside {[`PLS_HTOT_MIN:`PLS_HTOT_MAX]}
        && frame_total_lines inside {[`PLS_VTOT_MIN:`PLS_VTOT_MAX]};
    // Everything drops with the rail: an unpowered sink answers nothing
    always_ff @(posedge clk) begin
        if (rst || !panel_supply_rail) begin
            up_cnt_r      <= 8'h00;
            hotplug       <= 1'b0;
            train_done    <= 1'b0;
            frame_aligned <= 1'b0;
            tried_r       <= 1'b0;
            sink_status   <= 1'b0;
        end else begin
            if (up_cnt_r != 8'(HPD_DLY)) begin
                up_cnt_r <= up_cnt_r + 8'h01;
            end
            hotplug       <= (up_cnt_r == 8'(HPD_DLY)) && !hpd_block;
            train_done    <= train_req;
            frame_aligned <= idle_pattern;
            tried_r       <= tried_r || train_req;
            sink_status   <= video_valid && !novideo_flag && timing_ok;
        end
    end
    assign caps_done   = hotplug;
    assign train_fail  = train_req && !tried_r;
    assign black_video = !sink_status;
endmodule // pls_panel_model

//--- dv/pls_host_seq_tb.sv
// Testbench of the panel power sequencer
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_host_seq_tb;
    logic                   clk, rst, reg_wr, reg_rd, hpd_block;
    logic [`PLS_ADDR_W-1:0] reg_addr;
    logic [31:0]            reg_wdata, reg_rdata;
    logic                   hotplug, caps_done, train_done, train_fail, frame_aligned;
    logic                   rail, led, dim, bl, train_req, idle_pattern, video_valid, novideo, m48;
    logic                   sink_status, black_video;
    logic [`PLS_HTOT_W-1:0] htot;
    logic [`PLS_VTOT_W-1:0] vtot;
    logic [8:0]             outs;
    int                     fails, n_compared;
    assign outs = {rail, led, dim, bl, train_req, idle_pattern, video_valid, novideo, m48};

    localparam int LED_CYC = 3;
    pls_host_seq #(.HPD_WAIT_CYC(20), .VID_SETTLE_CYC(8), .BL_LEAD_CYC(5), .LED_UP_CYC(LED_CYC),
        .LED_DOWN_CYC(LED_CYC), .REST_CYC(10)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hotplug(hotplug),
        .caps_done(caps_done), .train_done(train_done), .train_fail(train_fail), .frame_aligned(frame_aligned),
        .panel_supply_rail(rail), .led_supply(led), .dimming_en(dim), .backlight_en(bl), .train_req(train_req),
        .idle_pattern(idle_pattern), .video_valid(video_valid), .novideo_flag(novideo), .pixel_clock_48(m48),
        .line_total_clocks(htot), .frame_total_lines(vtot));
    pls_panel_model u_panel (.clk(clk), .rst(rst), .hpd_block(hpd_block),
        .panel_supply_rail(rail), .train_req(train_req), .idle_pattern(idle_pattern), .video_valid(video_valid),
        .novideo_flag(novideo), .line_total_clocks(htot), .frame_total_lines(vtot), .hotplug(hotplug),
        .caps_done(caps_done), .train_done(train_done), .train_fail(train_fail), .frame_aligned(frame_aligned),
        .sink_status(sink_status), .black_video(black_video));

    always #5 clk = ~clk;

    // ****************
    // Access and compare tasks
    // ****************
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // Data stand one cycle only, so sample just past it
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rdc(string what, logic [3:0] a, logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic wait_st(logic [3:0] s);
        logic [31:0] d;
        for (int i = 0; i < 300; i++) begin
            rd(`PLS_ADDR_STATUS, d);
            if (d[3:0] === s) return;
        end
        fails++;
        $display("BAD state wait expected %h seen %h", s, d[3:0]);
        stop_test();
    endtask

    // ****************
    // Test sequence
    // ****************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        hpd_block = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("status", `PLS_ADDR_STATUS, 32'h00000000);
        rdc("htotal", `PLS_ADDR_HTOTAL, 32'h000008CA);
        rdc("vtotal", `PLS_ADDR_VTOTAL, 32'h0000046C);
        rdc("unmapped", 4'h2, 32'h00000000);
        chk("outputs", 32'h00000002, {23'h0, outs});
        $display("test reset done");
        // Line total one above range blocks power-up
        wr(`PLS_ADDR_HTOTAL, 32'h000008DF);
        wr(`PLS_ADDR_CTRL, 32'h00000001);
        rdc("err_tim", `PLS_ADDR_STATUS, 32'h00000200);
        chk("outputs", 32'h00000002, {23'h0, outs});
        wr(`PLS_ADDR_STATUS, 32'h00000200);
        wr(`PLS_ADDR_HTOTAL, 32'h000008B6);
        wr(`PLS_ADDR_VTOTAL, 32'h00000470);
        rdc("htotal", `PLS_ADDR_HTOTAL, 32'h000008B6);
        rdc("vtotal", `PLS_ADDR_VTOTAL, 32'h00000470);
        rdc("status", `PLS_ADDR_STATUS, 32'h00000000);
        $display("test range done");
        // Full power-up at 48 Hz with boundary totals
        wr(`PLS_ADDR_CTRL, 32'h00000003);
        wait_st(4'h8);
        chk("outputs", 32'h000001E5, {23'h0, outs});
        chk("sink", 32'h00000002, {30'h0, sink_status, black_video});
        rdc("status", `PLS_ADDR_STATUS, 32'h00000018);
        wr(`PLS_ADDR_HTOTAL, 32'h000008C0);
        rdc("htotal", `PLS_ADDR_HTOTAL, 32'h000008B6);
        $display("test power on done");
        // Orderly shutdown
        wr(`PLS_ADDR_CTRL, 32'h00000000);
        wait_st(4'hD);
        chk("outputs", 32'h00000003, {23'h0, outs});
        chk("sink", 32'h00000001, {30'h0, sink_status, black_video});
        wait_st(4'h0);
        $display("test power off done");
        // Panel never raises hot-plug
        @(posedge clk);
        hpd_block <= 1'b1;
        wr(`PLS_ADDR_CTRL, 32'h00000001);
        wait_st(4'hD);
        rdc("err_hpd", `PLS_ADDR_STATUS, 32'h0000010D);
        chk("outputs", 32'h00000002, {23'h0, outs});
        wr(`PLS_ADDR_CTRL, 32'h00000000);
        wr(`PLS_ADDR_STATUS, 32'h00000100);
        @(posedge clk);
        hpd_block <= 1'b0;
        wait_st(4'h0);
        rdc("status", `PLS_ADDR_STATUS, 32'h00000000);
        $display("test hotplug timeout done");
        stop_test();
    end
endmodule // pls_host_seq_tb
